// *** hdl/oaau_pkg.sv ***
// constants and types of the operand addressing arithmetic unit
package oaau_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ARITH_NS    = 1000;
  localparam int T_TPINC_NS    = 2000;
  localparam int T_MULDIV_NS   = 4000;
  localparam logic [7:0] CYC_ARITH  = 8'(T_ARITH_NS / CLK_PERIOD_NS);
  localparam logic [7:0] CYC_TPINC  = 8'(T_TPINC_NS / CLK_PERIOD_NS);
  localparam logic [7:0] CYC_MULDIV = 8'(T_MULDIV_NS / CLK_PERIOD_NS);
  localparam int PSW_CY  = 7;
  localparam int PSW_AC  = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV  = 2;
  localparam int PSW_P   = 0;
  localparam logic [7:0]  PSW_RST = 8'h00;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [7:0]  AUX_RST = 8'h00;
  localparam logic [15:0] TP_RST  = 16'h0000;
  localparam logic [7:0]  SFR_BASE = 8'h80;
  localparam int OPC_RI_BIT      = 0;
  localparam int OPC_PC_BASE_BIT = 4;
  localparam logic [3:0] BCD_MAX     = 4'h9;
  localparam logic [8:0] DA_LOW_FIX  = 9'h006;
  localparam logic [8:0] DA_HIGH_FIX = 9'h060;
  localparam logic [7:0] DIV_ZERO_RES = 8'hFF;
  typedef enum logic [3:0] {
    OP_ADD  = 4'h0, OP_ADD_WITH_CARRY = 4'h1, OP_SUBTRACT_WITH_BORROW = 4'h2, OP_INC  = 4'h3,
    OP_DEC  = 4'h4, OP_TPINC = 4'h5, OP_MUL = 4'h6, OP_DIV  = 4'h7,
    OP_DA   = 4'h8, OP_MOVC = 4'h9, OP_JMP  = 4'hA
  } oaau_op_t;
  typedef enum logic [2:0] {
    M_ACC  = 3'h0, M_DIR  = 3'h1, M_INDR = 3'h2, M_INDSP = 3'h3,
    M_REG  = 3'h4, M_IMM  = 3'h5, M_XTP  = 3'h6, M_XR    = 3'h7
  } oaau_mode_t;
  typedef enum logic [1:0] {
    SP_IRAM = 2'h0, SP_SFR = 2'h1, SP_XRAM = 2'h2, SP_CODE = 2'h3
  } oaau_space_t;
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0, S_START = 3'h1, S_PTRRQ = 3'h2, S_PTRGET = 3'h3,
    S_OPRRQ = 3'h4, S_OPRGET = 3'h5, S_EXEC = 3'h6, S_HOLD = 3'h7
  } oaau_state_t;
endpackage

// *** hdl/oaau_alu.sv ***
// combinational arithmetic of the operand addressing unit
`timescale 1ns/1ns
module oaau_alu (
  input  wire oaau_pkg::oaau_op_t op,
  input  wire logic [7:0]         a,
  input  wire logic [7:0]         opnd,
  input  wire logic [7:0]         aux,
  input  wire logic               cy_i,
  input  wire logic               ac_i,
  output logic      [7:0]         res,
  output logic      [7:0]         res_aux,
  output logic                    cy_o,
  output logic                    ac_o,
  output logic                    ov_o
);
  import oaau_pkg::*;
  logic [8:0]  wide;
  logic [4:0]  nib;
  logic [15:0] prod;
  logic [8:0]  da;
  logic        cin;
  always_comb begin
    res     = a;
    res_aux = aux;
    cy_o    = cy_i;
    ac_o    = ac_i;
    ov_o    = 1'b0;
    cin     = (op == OP_ADD_WITH_CARRY) && cy_i;
    prod    = {8'h00, a} * {8'h00, aux};
    wide    = 9'h000;
    nib     = 5'h00;
    da      = {1'b0, a};
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        wide = {1'b0, a} + {1'b0, opnd} + {8'h00, cin};
        nib  = {1'b0, a[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
        res  = wide[7:0];
        cy_o = wide[8];
        ac_o = nib[4];
        ov_o = (a[7] == opnd[7]) && (wide[7] != a[7]);
      end
      OP_SUBTRACT_WITH_BORROW: begin
        wide = {1'b0, a} - {1'b0, opnd} - {8'h00, cy_i};
        nib  = {1'b0, a[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cy_i};
        res  = wide[7:0];
        cy_o = wide[8];
        ac_o = nib[4];
        ov_o = (a[7] != opnd[7]) && (wide[7] != a[7]);
      end
      OP_INC: res = opnd + 8'h01;
      OP_DEC: res = opnd - 8'h01;
      OP_MUL: begin
        res     = prod[7:0];
        res_aux = prod[15:8];
        cy_o    = 1'b0;
        ov_o    = |prod[15:8];
      end
      OP_DIV: begin
        cy_o = 1'b0;
        if (aux == 8'h00) begin
          res     = DIV_ZERO_RES;
          res_aux = DIV_ZERO_RES;
          ov_o    = 1'b1;
        end else begin
          res     = a / aux;
          res_aux = a % aux;
        end
      end
      OP_DA: begin
        if ((a[3:0] > BCD_MAX) || ac_i) begin
          da = da + DA_LOW_FIX;
        end
        if ((da[7:4] > BCD_MAX) || cy_i || da[8]) begin
          da = da + DA_HIGH_FIX;
        end
        res  = da[7:0];
        cy_o = cy_i | da[8];
      end
      default: res = a;
    endcase
  end
endmodule // oaau_alu

// *** hdl/oaau_core.sv ***
// operand addressing and arithmetic datapath of an 8-bit core
// Notes on behaviour
// - direct operand location is the 8-bit address byte of the instruction
// - direct addresses reach lower 128 RAM bytes or sfr space only
// - 8-bit indirect address comes from pointer reg zero/one or stack pointer
// - only the table pointer supplies a 16-bit indirect address
// - indirect access reaches both internal and external RAM
// - 3-bit opcode field picks one of eight working registers, no byte
// - register bank is taken from status word at execution time
// - bank select bits are status bits 4 and 3; bank n at 8 times n
// - accumulator-implicit opcodes carry no address byte
// - immediate value is the program byte right after the opcode
// - indexed access reads program memory only, base plus accumulator
// - computed jump loads program counter with base plus accumulator
// - increment and decrement work in place on any internal byte
// - table pointer increment is one 16-bit add with carry across bytes
// - table pointer drives 16-bit external memory addresses
// - multiply gives 16-bit product, high to aux, low to accumulator
// - divide gives quotient to accumulator and remainder to aux
// - arithmetic takes 1 us, pointer increment 2 us, mul and div 4 us
// - decimal adjust corrects accumulator after adding two bcd bytes
// - parity flag is one when accumulator holds odd count of ones
`timescale 1ns/1ns
module oaau_core (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    instr_valid,
  input  wire oaau_pkg::oaau_op_t      instr_op,
  input  wire oaau_pkg::oaau_mode_t    instr_mode,
  input  wire logic [7:0]              instr_opcode,
  input  wire logic [7:0]              instr_byte,
  input  wire logic [15:0]             pc_value,
  input  wire logic [7:0]              stack_pointer,
  input  wire logic                    acc_wr,
  input  wire logic [7:0]              acc_wdata,
  input  wire logic                    aux_wr,
  input  wire logic [7:0]              aux_wdata,
  input  wire logic                    tp_wr,
  input  wire logic [15:0]             tp_wdata,
  input  wire logic                    status_wr,
  input  wire logic [7:0]              status_wdata,
  input  wire logic [7:0]              mem_rdata,
  output logic                         busy,
  output logic                         done,
  output logic                         mem_req,
  output logic                         mem_we,
  output oaau_pkg::oaau_space_t        mem_space,
  output logic [15:0]                  mem_addr,
  output logic [7:0]                   mem_wdata,
  output logic                         pc_load,
  output logic [15:0]                  pc_target,
  output logic [7:0]                   accumulator,
  output logic [7:0]                   aux_reg,
  output logic [15:0]                  table_pointer,
  output logic [7:0]                   status_word
);
  import oaau_pkg::*;

  oaau_state_t state_q;
  oaau_op_t    op_q;
  oaau_mode_t  mode_q;
  oaau_space_t opr_space;
  logic [7:0]  opc_q;
  logic [7:0]  byte_q;
  logic [7:0]  ptr_q;
  logic [7:0]  opnd_q;
  logic [7:0]  cnt_q;
  logic [7:0]  cyc_q;
  logic [15:0] pc_q;
  logic [15:0] opr_addr;
  logic [7:0]  opnd_val;
  logic [7:0]  alu_res;
  logic [7:0]  alu_aux;
  logic        alu_cy;
  logic        alu_ac;
  logic        alu_ov;
  logic        ptr_mode;
  logic        mem_opnd;
  logic        write_back;
  logic [1:0]  bank;

  // bank select read live, so the bank at execution time is used
  assign bank = status_word[PSW_RS1:PSW_RS0];
  assign ptr_mode = (mode_q == M_INDR) || (mode_q == M_XR);
  assign mem_opnd = (op_q == OP_MOVC) ||
    (((op_q == OP_ADD) || (op_q == OP_ADD_WITH_CARRY) || (op_q == OP_SUBTRACT_WITH_BORROW) ||
      (op_q == OP_INC) || (op_q == OP_DEC)) &&
     (mode_q != M_ACC) && (mode_q != M_IMM));
  assign write_back = ((op_q == OP_INC) || (op_q == OP_DEC)) &&
    (mode_q != M_ACC) && (mode_q != M_IMM) &&
    (mode_q != M_XTP) && (mode_q != M_XR);

  // operand location from the latched instruction
  always_comb begin
    opr_space = SP_IRAM;
    opr_addr  = 16'h0000;
    if (op_q == OP_MOVC) begin
      opr_space = SP_CODE;
      opr_addr  = (opc_q[OPC_PC_BASE_BIT] ? pc_q : table_pointer) +
                  {8'h00, accumulator};
    end else begin
      case (mode_q)
        M_DIR: begin
          opr_addr  = {8'h00, byte_q};
          opr_space = (byte_q < SFR_BASE) ? SP_IRAM : SP_SFR;
        end
        M_INDR:  opr_addr = {8'h00, ptr_q};
        M_INDSP: opr_addr = {8'h00, stack_pointer};
        M_REG:   opr_addr = {8'h00, 3'b000, bank, opc_q[2:0]};
        M_XTP: begin
          opr_space = SP_XRAM;
          opr_addr  = table_pointer;
        end
        M_XR: begin
          opr_space = SP_XRAM;
          opr_addr  = {8'h00, ptr_q};
        end
        default: opr_addr = 16'h0000;
      endcase
    end
  end

  // accumulator-implicit and immediate operands need no memory read
  always_comb begin
    case (mode_q)
      M_ACC:   opnd_val = accumulator;
      M_IMM:   opnd_val = byte_q;
      default: opnd_val = opnd_q;
    endcase
  end

  oaau_alu u_alu (
    .op      (op_q),
    .a       (accumulator),
    .opnd    (opnd_val),
    .aux     (aux_reg),
    .cy_i    (status_word[PSW_CY]),
    .ac_i    (status_word[PSW_AC]),
    .res     (alu_res),
    .res_aux (alu_aux),
    .cy_o    (alu_cy),
    .ac_o    (alu_ac),
    .ov_o    (alu_ov)
  );

  // sequencer and memory port
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= S_IDLE;
      op_q      <= OP_ADD;
      mode_q    <= M_ACC;
      opc_q     <= 8'h00;
      byte_q    <= 8'h00;
      pc_q      <= 16'h0000;
      ptr_q     <= 8'h00;
      opnd_q    <= 8'h00;
      cnt_q     <= 8'h00;
      cyc_q     <= CYC_ARITH;
      busy      <= 1'b0;
      done      <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_space <= SP_IRAM;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_req <= 1'b0;
      mem_we  <= 1'b0;
      done    <= 1'b0;
      cnt_q   <= cnt_q + 8'h01;
      case (state_q)
        S_IDLE: begin
          cnt_q <= 8'h00;
          if (instr_valid) begin
            op_q    <= instr_op;
            mode_q  <= instr_mode;
            opc_q   <= instr_opcode;
            byte_q  <= instr_byte;
            pc_q    <= pc_value;
            busy    <= 1'b1;
            state_q <= S_START;
            case (instr_op)
              OP_TPINC:       cyc_q <= CYC_TPINC;
              OP_MUL, OP_DIV: cyc_q <= CYC_MULDIV;
              default:        cyc_q <= CYC_ARITH;
            endcase
          end
        end
        S_START: begin
          if (mem_opnd && ptr_mode && (op_q != OP_MOVC)) begin
            mem_req   <= 1'b1;
            mem_space <= SP_IRAM;
            mem_addr  <= {8'h00, 3'b000, bank, 2'b00,
                          opc_q[OPC_RI_BIT]};
            state_q   <= S_PTRRQ;
          end else if (mem_opnd) begin
            mem_req   <= 1'b1;
            mem_space <= opr_space;
            mem_addr  <= opr_addr;
            state_q   <= S_OPRRQ;
          end else begin
            state_q <= S_EXEC;
          end
        end
        S_PTRRQ: state_q <= S_PTRGET;
        S_PTRGET: begin
          ptr_q   <= mem_rdata;
          state_q <= S_OPRRQ;
          mem_req <= 1'b1;
          mem_space <= (mode_q == M_XR) ? SP_XRAM : SP_IRAM;
          mem_addr  <= {8'h00, mem_rdata};
        end
        S_OPRRQ: state_q <= S_OPRGET;
        S_OPRGET: begin
          opnd_q  <= mem_rdata;
          state_q <= S_EXEC;
        end
        S_EXEC: begin
          if (write_back) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_space <= opr_space;
            mem_addr  <= opr_addr;
            mem_wdata <= alu_res;
          end
          state_q <= S_HOLD;
        end
        S_HOLD: begin
          if (cnt_q == cyc_q - 8'h01) begin
            busy    <= 1'b0;
            done    <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // accumulator, aux, table pointer and jump target
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accumulator   <= ACC_RST;
      aux_reg       <= AUX_RST;
      table_pointer <= TP_RST;
      pc_load       <= 1'b0;
      pc_target     <= 16'h0000;
    end else begin
      pc_load <= 1'b0;
      if (state_q == S_EXEC) begin
        case (op_q)
          OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_DA: accumulator <= alu_res;
          OP_INC, OP_DEC: begin
            if (mode_q == M_ACC) begin
              accumulator <= alu_res;
            end
          end
          OP_TPINC: table_pointer <= table_pointer + 16'h0001;
          OP_MUL, OP_DIV: begin
            accumulator <= alu_res;
            aux_reg     <= alu_aux;
          end
          OP_MOVC: accumulator <= opnd_q;
          OP_JMP: begin
            pc_load   <= 1'b1;
            pc_target <= (opc_q[OPC_PC_BASE_BIT] ? pc_q : table_pointer) +
                         {8'h00, accumulator};
          end
          default: accumulator <= accumulator;
        endcase
      end else begin
        if (acc_wr) begin
          accumulator <= acc_wdata;
        end
        if (aux_wr) begin
          aux_reg <= aux_wdata;
        end
        if (tp_wr) begin
          table_pointer <= tp_wdata;
        end
      end
    end
  end

  // status word: flags from arithmetic, parity from accumulator
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_word <= PSW_RST;
    end else begin
      status_word[PSW_P] <= ^accumulator;
      if (state_q == S_EXEC) begin
        case (op_q)
          OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
            status_word[PSW_CY] <= alu_cy;
            status_word[PSW_AC] <= alu_ac;
            status_word[PSW_OV] <= alu_ov;
          end
          OP_MUL, OP_DIV: begin
            status_word[PSW_CY] <= alu_cy;
            status_word[PSW_OV] <= alu_ov;
          end
          OP_DA: status_word[PSW_CY] <= alu_cy;
          default: status_word[PSW_CY] <= status_word[PSW_CY];
        endcase
      end else if (status_wr) begin
        status_word[7:1] <= status_wdata[7:1];
      end
    end
  end

  // checks
  logic [7:0] busy_len_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_len_q <= 8'h00;
    end else if (busy) begin
      busy_len_q <= busy_len_q + 8'h01;
    end else if (!done) begin
      busy_len_q <= 8'h00;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_exec(oaau_op_t o);
    (state_q == S_EXEC) && (op_q == o);
  endsequence

  property p_dir_low;
    mem_req && (mode_q == M_DIR) && (op_q != OP_MOVC) |->
      (mem_addr[15:8] == 8'h00) &&
      ((mem_space == SP_IRAM) == (mem_addr[7:0] < SFR_BASE));
  endproperty
  a_dir_low: assert property (p_dir_low)
    else $error("direct access selected upper ram");

  property p_reg_bank;
    (state_q == S_START) && (mode_q == M_REG) && mem_opnd && !status_wr |=>
      mem_req && (mem_addr == {11'h000, bank, opc_q[2:0]});
  endproperty
  a_reg_bank: assert property (p_reg_bank)
    else $error("register operand address wrong");

  property p_tp_ext;
    mem_req && (mode_q == M_XTP) && (op_q != OP_MOVC) |->
      (mem_space == SP_XRAM) && (mem_addr == table_pointer);
  endproperty
  a_tp_ext: assert property (p_tp_ext)
    else $error("16-bit indirect not from table pointer");

  property p_code_ro;
    mem_req && (mem_space == SP_CODE) |-> !mem_we;
  endproperty
  a_code_ro: assert property (p_code_ro)
    else $error("program memory written");

  property p_jmp;
    s_exec(OP_JMP) && !opc_q[OPC_PC_BASE_BIT] |=>
      pc_load && (pc_target == $past(table_pointer) +
                  {8'h00, $past(accumulator)});
  endproperty
  a_jmp: assert property (p_jmp)
    else $error("computed jump target wrong");

  property p_tpinc;
    s_exec(OP_TPINC) |=> table_pointer == $past(table_pointer) + 16'h0001;
  endproperty
  a_tpinc: assert property (p_tpinc)
    else $error("table pointer increment wrong");

  property p_mul;
    s_exec(OP_MUL) |=>
      ({aux_reg, accumulator} == {8'h00, $past(accumulator)} *
                                 {8'h00, $past(aux_reg)}) &&
      !status_word[PSW_CY] && (status_word[PSW_OV] == (aux_reg != 8'h00));
  endproperty
  a_mul: assert property (p_mul)
    else $error("multiply result or flags wrong");

  property p_div;
    s_exec(OP_DIV) && (aux_reg != 8'h00) |=>
      (accumulator == $past(accumulator) / $past(aux_reg)) &&
      (aux_reg == $past(accumulator) % $past(aux_reg));
  endproperty
  a_div: assert property (p_div)
    else $error("divide result wrong");

  property p_add_with_carry;
    s_exec(OP_ADD_WITH_CARRY) |=> accumulator == $past(accumulator) +
      $past(opnd_val) + {7'h00, $past(status_word[PSW_CY])};
  endproperty
  a_add_with_carry: assert property (p_add_with_carry)
    else $error("add with carry result wrong");

  property p_inc_mem;
    s_exec(OP_INC) && write_back |=>
      mem_req && mem_we && (mem_wdata == $past(opnd_q) + 8'h01);
  endproperty
  a_inc_mem: assert property (p_inc_mem)
    else $error("in-place increment wrong");

  property p_timing;
    done |-> busy_len_q == cyc_q;
  endproperty
  a_timing: assert property (p_timing)
    else $error("instruction length wrong");

  property p_parity;
    done |-> status_word[PSW_P] == ^accumulator;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity flag wrong");
endmodule // oaau_core

// *** sim/oaau_mem_model.sv ***
// memory model answering the core's operand accesses
`timescale 1ns/1ns
module oaau_mem_model (
  input  wire logic                  core_clk,
  input  wire logic                  mem_req,
  input  wire logic                  mem_we,
  input  wire oaau_pkg::oaau_space_t mem_space,
  input  wire logic [15:0]           mem_addr,
  input  wire logic [7:0]            mem_wdata,
  output logic      [7:0]            mem_rdata
);
  import oaau_pkg::*;
  logic [7:0] iram [256];
  logic [7:0] sfr  [128];
  logic [7:0] data_q;
  logic       vld_q;
  initial begin
    data_q = 8'h00;
    vld_q  = 1'b0;
    for (int i = 0; i < 256; i++) begin
      iram[i] = 8'(i) ^ 8'h5A;
    end
    for (int i = 0; i < 128; i++) begin
      sfr[i] = 8'(i) ^ 8'hA5;
    end
  end
  // external and program bytes follow from the whole 16-bit address
  always @(posedge core_clk) begin
    vld_q <= mem_req && !mem_we;
    if (mem_req && mem_we && mem_space == SP_IRAM) begin
      iram[mem_addr[7:0]] <= mem_wdata;
    end
    if (mem_req && mem_we && mem_space == SP_SFR) begin
      sfr[mem_addr[6:0]] <= mem_wdata;
    end
    // program space has no write path
    if (mem_req && !mem_we) begin
      case (mem_space)
        SP_IRAM: data_q <= iram[mem_addr[7:0]];
        SP_SFR:  data_q <= sfr[mem_addr[6:0]];
        SP_XRAM: data_q <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3C;
        default: data_q <= (mem_addr[7:0] + mem_addr[15:8]) ^ 8'hC3;
      endcase
    end
  end
  // outside the answer cycle the line shows the inverse of the last byte
  assign mem_rdata = vld_q ? data_q : ~data_q;
endmodule // oaau_mem_model

// *** sim/tb_operand_addressing_arith_unit.sv ***
// self-checking bench of the operand addressing arithmetic unit
`timescale 1ns/1ns
module tb_operand_addressing_arith_unit;
  import oaau_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
  logic        acc_wr = 1'b0, aux_wr = 1'b0, tp_wr = 1'b0, status_wr = 1'b0;
  oaau_op_t    instr_op = OP_ADD;
  oaau_mode_t  instr_mode = M_ACC;
  logic [7:0]  instr_opcode = 8'h00, instr_byte = 8'h00;
  logic [7:0]  stack_pointer = 8'h00, acc_wdata = 8'h00;
  logic [7:0]  aux_wdata = 8'h00, status_wdata = 8'h00;
  logic [15:0] pc_value = 16'h0000, tp_wdata = 16'h0000;
  logic [7:0]  mem_rdata, mem_wdata, accumulator, aux_reg, status_word;
  logic [15:0] mem_addr, pc_target, table_pointer;
  logic [15:0] jump_q = 16'h0000;
  logic        busy, done, mem_req, mem_we, pc_load;
  oaau_space_t mem_space;
  int          err_total = 0, checked = 0;

  oaau_core dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_mode(instr_mode),
    .instr_opcode(instr_opcode), .instr_byte(instr_byte),
    .pc_value(pc_value), .stack_pointer(stack_pointer),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata), .aux_wr(aux_wr),
    .aux_wdata(aux_wdata), .tp_wr(tp_wr), .tp_wdata(tp_wdata),
    .status_wr(status_wr), .status_wdata(status_wdata),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .mem_req(mem_req),
    .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .pc_load(pc_load), .pc_target(pc_target),
    .accumulator(accumulator), .aux_reg(aux_reg),
    .table_pointer(table_pointer), .status_word(status_word)
  );

  oaau_mem_model mem_u (
    .core_clk(core_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );

  always #10 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // software writes of accumulator, aux and status in one strobe cycle
  task automatic setr(input logic [7:0] a, input logic [7:0] x,
                      input logic [7:0] s);
    acc_wr = 1'b1;
    acc_wdata = a;
    aux_wr = 1'b1;
    aux_wdata = x;
    status_wr = 1'b1;
    status_wdata = s;
    @(posedge core_clk);
    #1;
    acc_wr = 1'b0;
    aux_wr = 1'b0;
    status_wr = 1'b0;
  endtask

  task automatic settp(input logic [15:0] t);
    tp_wr = 1'b1;
    tp_wdata = t;
    @(posedge core_clk);
    #1;
    tp_wr = 1'b0;
  endtask

  // one instruction: start, count busy cycles, wait for done
  task automatic run(input oaau_op_t o, input oaau_mode_t m,
                     input logic [7:0] opc, input logic [7:0] b,
                     input logic [7:0] n);
    int c;
    c = 0;
    instr_op = o;
    instr_mode = m;
    instr_opcode = opc;
    instr_byte = b;
    instr_valid = 1'b1;
    @(posedge core_clk);
    #1;
    instr_valid = 1'b0;
    for (int k = 0; k < 400 && done !== 1'b1; k++) begin
      if (busy === 1'b1) c++;
      @(posedge core_clk);
      #1;
    end
    chk(16'(c), 16'(n));
    @(posedge core_clk);
    #1;
    chk(16'(status_word[PSW_P]), 16'(^accumulator));
  endtask

  always @(posedge core_clk) begin
    if (pc_load === 1'b1) jump_q <= pc_target;
    if (mem_req === 1'b1 && mem_space === SP_CODE) begin
      chk(16'(mem_we), 16'h0000);
    end
  end

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    // add from a direct address: half carry and signed overflow
    mem_u.iram[8'h30] = 8'h01;
    setr(8'h7F, 8'h00, 8'h00);
    run(OP_ADD, M_DIR, 8'h00, 8'h30, CYC_ARITH);
    chk(16'(accumulator), 16'h0080);
    chk(16'(status_word), 16'h0045);
    // direct address above 7F lands in register space
    mem_u.sfr[7'h10] = 8'h44;
    setr(8'h00, 8'h00, 8'h00);
    run(OP_ADD, M_DIR, 8'h00, 8'h90, CYC_ARITH);
    chk(16'(accumulator), 16'h0044);
    // add with carry and subtract with borrow on immediates
    setr(8'h0F, 8'h00, 8'h80);
    run(OP_ADD_WITH_CARRY, M_IMM, 8'h00, 8'h10, CYC_ARITH);
    chk(16'(accumulator), 16'h0020);
    chk(16'(status_word), 16'h0041);
    setr(8'h00, 8'h00, 8'h80);
    run(OP_SUBTRACT_WITH_BORROW, M_IMM, 8'h00, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h00FF);
    chk(16'(status_word), 16'h00C0);
    // working register 5 in each bank
    for (int b = 0; b < 4; b++) begin
      mem_u.iram[8 * b + 5] = 8'(b + 1);
      setr(8'h10, 8'h00, 8'(b << 3));
      run(OP_ADD, M_REG, 8'h05, 8'h00, CYC_ARITH);
      chk(16'(accumulator), 16'(8'h11 + 8'(b)));
    end
    // pointer reg one of bank 1 reaching upper ram
    mem_u.iram[8'h09] = 8'hA0;
    mem_u.iram[8'hA0] = 8'h05;
    setr(8'h01, 8'h00, 8'h08);
    run(OP_ADD, M_INDR, 8'h01, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h0006);
    stack_pointer = 8'h41;
    mem_u.iram[8'h41] = 8'h02;
    setr(8'h01, 8'h00, 8'h00);
    run(OP_ADD, M_INDSP, 8'h00, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h0003);
    // external byte addressed by the table pointer
    settp(16'h1234);
    setr(8'h00, 8'h00, 8'h00);
    run(OP_ADD, M_XTP, 8'h00, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h001A);
    // external byte addressed by pointer reg zero of bank 0
    mem_u.iram[8'h00] = 8'h77;
    setr(8'h00, 8'h00, 8'h00);
    run(OP_ADD, M_XR, 8'h00, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h004B);
    // increment and decrement in place
    mem_u.iram[8'h31] = 8'hFF;
    mem_u.iram[8'h02] = 8'h00;
    setr(8'h55, 8'h00, 8'h00);
    run(OP_INC, M_DIR, 8'h00, 8'h31, CYC_ARITH);
    chk(16'(mem_u.iram[8'h31]), 16'h0000);
    run(OP_DEC, M_REG, 8'h02, 8'h00, CYC_ARITH);
    chk(16'(mem_u.iram[8'h02]), 16'h00FF);
    chk(16'(accumulator), 16'h0055);
    // table pointer increment across the byte boundary
    settp(16'h12FF);
    run(OP_TPINC, M_ACC, 8'h00, 8'h00, CYC_TPINC);
    chk(table_pointer, 16'h1300);
    // multiply and divide, carry preset to see it cleared
    setr(8'h50, 8'h10, 8'h80);
    run(OP_MUL, M_ACC, 8'h00, 8'h00, CYC_MULDIV);
    chk({aux_reg, accumulator}, 16'h0500);
    chk(16'(status_word), 16'h0004);
    setr(8'hFB, 8'h12, 8'h80);
    run(OP_DIV, M_ACC, 8'h00, 8'h00, CYC_MULDIV);
    chk({aux_reg, accumulator}, 16'h110D);
    chk(16'(status_word), 16'h0001);
    setr(8'h10, 8'h00, 8'h00);
    run(OP_DIV, M_ACC, 8'h00, 8'h00, CYC_MULDIV);
    chk(16'(status_word[PSW_OV]), 16'h0001);
    // bcd add directly followed by decimal adjust
    setr(8'h38, 8'h00, 8'h00);
    run(OP_ADD, M_IMM, 8'h00, 8'h49, CYC_ARITH);
    run(OP_DA, M_ACC, 8'h00, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h0087);
    // table reads from program memory, both bases
    pc_value = 16'h2000;
    setr(8'h05, 8'h00, 8'h00);
    run(OP_MOVC, M_ACC, 8'h10, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h00E6);
    settp(16'h1300);
    setr(8'h02, 8'h00, 8'h00);
    run(OP_MOVC, M_ACC, 8'h00, 8'h00, CYC_ARITH);
    chk(16'(accumulator), 16'h00D6);
    // computed jumps
    setr(8'hFF, 8'h00, 8'h00);
    run(OP_JMP, M_ACC, 8'h00, 8'h00, CYC_ARITH);
    chk(jump_q, 16'h13FF);
    pc_value = 16'h20F0;
    setr(8'h20, 8'h00, 8'h00);
    run(OP_JMP, M_ACC, 8'h10, 8'h00, CYC_ARITH);
    chk(jump_q, 16'h2110);
    report_and_stop();
  end
endmodule // tb_operand_addressing_arith_unit
